// ===== verilog/cat_pkg.sv
// Constants shared by the counter array timebase design.
// Assumes one system clock domain; everything is a localparam.
package cat_pkg;
    localparam int CNT_W = 16;
    localparam int BYTE_W = 8;
    localparam logic [15:0] CNT_RESET = 16'h0000;
    localparam logic [15:0] CNT_ALL_ONES = 16'hFFFF;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    // Timebase select codes
    localparam logic [2:0] TB_DIV12 = 3'h0;
    localparam logic [2:0] TB_DIV4 = 3'h1;
    localparam logic [2:0] TB_TIMER0 = 3'h2;
    localparam logic [2:0] TB_EXT_FALL = 3'h3;
    localparam logic [2:0] TB_SYSCLK = 3'h4;
    localparam logic [2:0] TB_EXT_OSC = 3'h5;
    localparam logic [2:0] TB_RTC_OSC = 3'h6;
    // Divider terminal counts (count runs 0..last)
    localparam logic [3:0] DIV12_LAST = 4'hB;
    localparam logic [3:0] DIV4_LAST = 4'h3;
    localparam logic [3:0] DIV_RESET = 4'h0;
    // Quiet cycles after an external edge tick: rate at most clock/4
    localparam logic [1:0] ECI_GAP = 2'h3;
    localparam logic [1:0] GAP_RESET = 2'h0;
    // Watchdog of module 5 is on out of reset
    localparam logic WD_RESET = 1'b1;
endpackage

// ===== verilog/cat_tb_source.sv
// Timebase source selector: dividers, synchronisers and edge detectors.
// Assumes pins are asynchronous to mclk; timer 0 overflow is an mclk pulse.
`timescale 1ns/1ps
`default_nettype none
module cat_tb_source (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic [2:0] timebase_select,
    input wire logic timer0_overflow,
    input wire logic external_count_input,
    input wire logic ext_osc_div8,
    input wire logic rtc_osc_div8,
    output logic count_tick
);
    typedef struct packed {
        logic [3:0] div;
        logic [1:0] gap;
        logic eci_meta;
        logic eci_sync;
        logic eci_prev;
        logic ext_meta;
        logic ext_sync;
        logic ext_prev;
        logic rtc_meta;
        logic rtc_sync;
        logic rtc_prev;
        logic tick;
    } cat_src_t;

    cat_src_t st_reg;
    cat_src_t st_next;
    logic [3:0] div_last;
    logic div_hit;
    logic eci_fall;

    // Divider, edge detection and source choice
    always_comb begin
        st_next = st_reg;
        div_last = (timebase_select == cat_pkg::TB_DIV4) ? cat_pkg::DIV4_LAST : cat_pkg::DIV12_LAST;
        div_hit = (st_reg.div >= div_last);
        st_next.div = div_hit ? cat_pkg::DIV_RESET : st_reg.div + 4'h1;
        // Two-flop synchronisers; only the second stage feeds logic
        st_next.eci_meta = external_count_input;
        st_next.eci_sync = st_reg.eci_meta;
        st_next.eci_prev = st_reg.eci_sync;
        st_next.ext_meta = ext_osc_div8;
        st_next.ext_sync = st_reg.ext_meta;
        st_next.ext_prev = st_reg.ext_sync;
        st_next.rtc_meta = rtc_osc_div8;
        st_next.rtc_sync = st_reg.rtc_meta;
        st_next.rtc_prev = st_reg.rtc_sync;
        // Falling edge from two successive samples, rate-limited
        eci_fall = st_reg.eci_prev & ~st_reg.eci_sync & (st_reg.gap == cat_pkg::GAP_RESET);
        st_next.gap = (st_reg.gap != cat_pkg::GAP_RESET) ? st_reg.gap - 2'h1 : st_reg.gap;
        case (timebase_select)
            cat_pkg::TB_DIV12: st_next.tick = div_hit;
            cat_pkg::TB_DIV4: st_next.tick = div_hit;
            cat_pkg::TB_TIMER0: st_next.tick = timer0_overflow;
            cat_pkg::TB_EXT_FALL: begin
                st_next.tick = eci_fall;
                if (eci_fall) begin
                    st_next.gap = cat_pkg::ECI_GAP;
                end
            end
            cat_pkg::TB_SYSCLK: st_next.tick = 1'b1;
            cat_pkg::TB_EXT_OSC: st_next.tick = st_reg.ext_sync & ~st_reg.ext_prev;
            cat_pkg::TB_RTC_OSC: st_next.tick = st_reg.rtc_sync & ~st_reg.rtc_prev;
            default: st_next.tick = 1'b0; // Unused code never counts
        endcase
    end

    // State register
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign count_tick = st_reg.tick;

    a_div12_spacing: assert property (@(posedge mclk) disable iff (!rstn)
        (count_tick && timebase_select == cat_pkg::TB_DIV12 && $stable(timebase_select))
        |=> (!count_tick || timebase_select != cat_pkg::TB_DIV12) [*8])
        else $error("divide-by-12 tick came too early");

    a_eci_spacing: assert property (@(posedge mclk) disable iff (!rstn)
        (count_tick && timebase_select == cat_pkg::TB_EXT_FALL && $past(timebase_select) == cat_pkg::TB_EXT_FALL)
        |=> (!count_tick || timebase_select != cat_pkg::TB_EXT_FALL) [*3])
        else $error("external edge ticks faster than clock/4");

    a_sysclk_tick: assert property (@(posedge mclk) disable iff (!rstn)
        (timebase_select == cat_pkg::TB_SYSCLK) ##1 (timebase_select == cat_pkg::TB_SYSCLK) |-> count_tick)
        else $error("undivided clock source did not tick");
endmodule
`default_nettype wire

// ===== verilog/cat_timebase.sv
// Shared 16-bit counter of the counter array with snapshot reads,
// overflow flag, interrupt gating, idle control and watchdog lockout.
// Assumes CPU strobes are single-cycle mclk pulses; pins are async.
//
// Behaviour
// - One 16-bit counter read as two bytes.
// - Low-byte read latches high byte for next read.
// - Byte reads never disturb counting.
// - Wrap from all-ones sets overflow flag.
// - Overflow interrupt only while its enable set.
// - Flag cleared only by software write.
// - Interrupt needs global and array enables.
// - Idle-control zero keeps counting during idle.
// - Select codes pick clock/12, clock/4, timer0, clock.
// - Code 011 counts external falling edges, limited.
// - Codes 101/110 count divided oscillators.
// - Divided oscillators synchronised to system clock.
// - Count is common reference for six modules.
// - Watchdog on after reset restricts access.
`timescale 1ns/1ps
`default_nettype none
module cat_timebase (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic low_byte_rd,
    input wire logic high_byte_rd,
    input wire logic low_byte_wr,
    input wire logic high_byte_wr,
    input wire logic [7:0] wr_data,
    input wire logic flag_clear,
    input wire logic watchdog_disable,
    input wire logic [2:0] timebase_select,
    input wire logic overflow_irq_enable,
    input wire logic idle_suspend_control,
    input wire logic cpu_idle,
    input wire logic global_irq_enable,
    input wire logic array_irq_enable,
    input wire logic timer0_overflow,
    input wire logic external_count_input,
    input wire logic ext_osc_div8,
    input wire logic rtc_osc_div8,
    output logic [7:0] rd_data,
    output logic rd_valid,
    output logic counter_overflow_flag,
    output logic irq_request,
    output logic [15:0] count_value,
    output logic count_advance,
    output logic watchdog_active,
    output logic write_refused
);
    typedef struct packed {
        logic [15:0] count;
        logic [7:0] snap;
        logic snap_valid;
        logic [7:0] rd_data;
        logic rd_valid;
        logic flag;
        logic wd_en;
        logic refused;
    } cat_state_t;

    cat_state_t st_reg;
    cat_state_t st_next;
    logic tick;
    logic run;
    logic wr_any;

    // Timebase source and its synchronisers
    cat_tb_source u_src (
        .mclk(mclk),
        .rstn(rstn),
        .timebase_select(timebase_select),
        .timer0_overflow(timer0_overflow),
        .external_count_input(external_count_input),
        .ext_osc_div8(ext_osc_div8),
        .rtc_osc_div8(rtc_osc_div8),
        .count_tick(tick)
    );

    // Counting, reads, writes and flag handling
    always_comb begin
        st_next = st_reg;
        run = tick & ~(cpu_idle & idle_suspend_control);
        wr_any = low_byte_wr | high_byte_wr;
        st_next.rd_valid = low_byte_rd | high_byte_rd;
        st_next.refused = wr_any & st_reg.wd_en;
        // Counting goes on regardless of reads
        if (run) begin
            st_next.count = st_reg.count + 16'h0001;
        end
        // Writes lose against nothing but the watchdog lockout
        if (!st_reg.wd_en) begin
            if (low_byte_wr) begin
                st_next.count[7:0] = wr_data;
            end
            if (high_byte_wr) begin
                st_next.count[15:8] = wr_data;
            end
        end
        if (watchdog_disable) begin
            st_next.wd_en = 1'b0;
        end
        // Low read snapshots the high byte for a coherent pair
        if (low_byte_rd) begin
            st_next.rd_data = st_reg.count[7:0];
            st_next.snap = st_reg.count[15:8];
            st_next.snap_valid = 1'b1;
        end else if (high_byte_rd) begin
            st_next.rd_data = st_reg.snap_valid ? st_reg.snap : st_reg.count[15:8];
            st_next.snap_valid = 1'b0;
        end
        // Software clear; a wrap in the same cycle wins
        if (flag_clear) begin
            st_next.flag = 1'b0;
        end
        if (run && st_reg.count == cat_pkg::CNT_ALL_ONES && !(wr_any && !st_reg.wd_en)) begin
            st_next.flag = 1'b1;
        end
    end

    // State register; watchdog starts enabled
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            st_reg.count <= cat_pkg::CNT_RESET;
            st_reg.snap <= cat_pkg::BYTE_RESET;
            st_reg.snap_valid <= 1'b0;
            st_reg.rd_data <= cat_pkg::BYTE_RESET;
            st_reg.rd_valid <= 1'b0;
            st_reg.flag <= 1'b0;
            st_reg.wd_en <= cat_pkg::WD_RESET;
            st_reg.refused <= 1'b0;
        end else begin
            st_reg <= st_next;
        end
    end

    // Interrupt needs flag, local enable and both global enables
    assign irq_request = st_reg.flag & overflow_irq_enable & global_irq_enable & array_irq_enable;
    assign rd_data = st_reg.rd_data;
    assign rd_valid = st_reg.rd_valid;
    assign counter_overflow_flag = st_reg.flag;
    // Time reference fanned out to the six compare modules
    assign count_value = st_reg.count;
    assign count_advance = run;
    assign watchdog_active = st_reg.wd_en;
    assign write_refused = st_reg.refused;

    sequence s_low_read;
        low_byte_rd && !high_byte_rd;
    endsequence

    sequence s_high_read;
        high_byte_rd && !low_byte_rd;
    endsequence

    a_snap_coherent: assert property (@(posedge mclk) disable iff (!rstn)
        s_low_read ##1 s_high_read |=> rd_data == $past(count_value[15:8], 2))
        else $error("high byte read did not return the snapshot");

    a_count_step: assert property (@(posedge mclk) disable iff (!rstn)
        (run && !low_byte_wr && !high_byte_wr) |=> count_value == $past(count_value) + 16'h0001)
        else $error("counter did not advance by one");

    a_read_quiet: assert property (@(posedge mclk) disable iff (!rstn)
        ((low_byte_rd || high_byte_rd) && !run && !low_byte_wr && !high_byte_wr) |=> $stable(count_value))
        else $error("read disturbed the counter");

    a_wrap_flag: assert property (@(posedge mclk) disable iff (!rstn)
        (run && count_value == cat_pkg::CNT_ALL_ONES && !((low_byte_wr || high_byte_wr) && !watchdog_active))
        |=> counter_overflow_flag && count_value == cat_pkg::CNT_RESET)
        else $error("wrap did not set the overflow flag");

    a_flag_sticky: assert property (@(posedge mclk) disable iff (!rstn)
        (counter_overflow_flag && !flag_clear) |=> counter_overflow_flag)
        else $error("overflow flag dropped without software clear");

    a_irq_enable: assert property (@(posedge mclk) disable iff (!rstn)
        irq_request |-> overflow_irq_enable && counter_overflow_flag)
        else $error("interrupt raised without its enable");

    a_irq_global: assert property (@(posedge mclk) disable iff (!rstn)
        !(global_irq_enable && array_irq_enable) |-> !irq_request)
        else $error("interrupt raised without global enables");

    a_idle_run: assert property (@(posedge mclk) disable iff (!rstn)
        (tick && cpu_idle && !idle_suspend_control) |-> count_advance)
        else $error("counter stalled in idle with control clear");

    a_idle_freeze: assert property (@(posedge mclk) disable iff (!rstn)
        (cpu_idle && idle_suspend_control && !low_byte_wr && !high_byte_wr) |=> $stable(count_value))
        else $error("counter moved while suspended in idle");

    a_wd_lockout: assert property (@(posedge mclk) disable iff (!rstn)
        (watchdog_active && low_byte_wr && !run) |=> $stable(count_value) && write_refused)
        else $error("counter write accepted under watchdog");
endmodule
`default_nettype wire

// ===== testbench/cat_src_model.sv
// Source model for the counter: timer 0 overflow, external pin, oscillators.
// Assumes it shares mclk and rstn with the counter; waveforms repeat every 16 cycles.
`timescale 1ns/1ps
`default_nettype none
module cat_src_model (
    input wire logic mclk,
    input wire logic rstn,
    output logic timer0_overflow,
    output logic external_count_input,
    output logic ext_osc_div8,
    output logic rtc_osc_div8
);
    logic [3:0] phase_reg;
    // Free running phase, so every window of 48 cycles sees a fixed edge count
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            phase_reg <= 4'h0;
        end else begin
            phase_reg <= phase_reg + 4'h1;
        end
    end
    // One overflow pulse every 8 cycles
    assign timer0_overflow = (phase_reg[2:0] == 3'h7);
    // Pin falls once per 16 cycles, well inside the clock/4 limit
    assign external_count_input = phase_reg[3];
    // Divided oscillators: one rising edge per 16 cycles, different phases
    assign ext_osc_div8 = phase_reg[3];
    assign rtc_osc_div8 = ~phase_reg[2] & ~phase_reg[3];
endmodule
`default_nettype wire

// ===== testbench/testbench.sv
// Self-checking bench for the counter array timebase.
// Assumes the source model drives timer 0, external pin and oscillators.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam logic [5:0] LR = 6'h01, HR = 6'h02, LW = 6'h04, HW = 6'h08, FC = 6'h10, WD = 6'h20;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic low_byte_rd = 1'b0, high_byte_rd = 1'b0, low_byte_wr = 1'b0, high_byte_wr = 1'b0;
    logic [7:0] wr_data = 8'h00;
    logic flag_clear = 1'b0, watchdog_disable = 1'b0;
    logic [2:0] timebase_select = 3'h7;
    logic overflow_irq_enable = 1'b0, idle_suspend_control = 1'b1, cpu_idle = 1'b1;
    logic global_irq_enable = 1'b1, array_irq_enable = 1'b1;
    wire logic timer0_overflow, external_count_input, ext_osc_div8, rtc_osc_div8;
    logic [7:0] rd_data;
    logic rd_valid, counter_overflow_flag, irq_request, count_advance, watchdog_active, write_refused;
    logic [15:0] count_value;
    logic [15:0] c1;
    int errors = 0, check_count = 0, cycles = 0;
    int rate [8] = '{4, 12, 6, 3, 48, 3, 3, 0};

    cat_src_model model (.mclk, .rstn, .timer0_overflow, .external_count_input, .ext_osc_div8,
        .rtc_osc_div8);
    cat_timebase dut (.mclk, .rstn, .low_byte_rd, .high_byte_rd, .low_byte_wr, .high_byte_wr,
        .wr_data, .flag_clear, .watchdog_disable, .timebase_select, .overflow_irq_enable,
        .idle_suspend_control, .cpu_idle, .global_irq_enable, .array_irq_enable,
        .timer0_overflow, .external_count_input, .ext_osc_div8, .rtc_osc_div8, .rd_data,
        .rd_valid, .counter_overflow_flag, .irq_request, .count_value, .count_advance,
        .watchdog_active, .write_refused);

    // 100 ns clock
    initial begin
        forever #50 mclk = ~mclk;
    end

    task automatic stop_test();
        if (errors == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Hang guard, far above the roughly 640 cycles the sequence needs
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            stop_test();
        end
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // One-cycle strobe, returns just after the edge that takes it
    task automatic strobe(input logic [5:0] s, input logic [7:0] d);
        @(posedge mclk);
        {watchdog_disable, flag_clear, high_byte_wr, low_byte_wr, high_byte_rd, low_byte_rd} <= s;
        wr_data <= d;
        @(posedge mclk);
        {watchdog_disable, flag_clear, high_byte_wr, low_byte_wr, high_byte_rd, low_byte_rd} <= 6'h00;
        #1;
    endtask

    task automatic rd(input logic [5:0] s, input logic [7:0] exp);
        strobe(s, 8'h00);
        chk(16'(rd_valid), 16'h0001);
        chk(16'(rd_data), 16'(exp));
    endtask

    initial begin
        repeat (5) @(posedge mclk);
        rstn <= 1'b1;
        #1;
        chk(count_value, 16'h0000);
        chk(16'(watchdog_active), 16'h0001);
        strobe(LW, 8'h55);
        chk(16'(write_refused), 16'h0001);
        chk(count_value, 16'h0000);
        strobe(WD, 8'h00);
        chk(16'(watchdog_active), 16'h0000);
        strobe(HW, 8'h12);
        chk(16'(write_refused), 16'h0000);
        strobe(LW, 8'hFE);
        chk(count_value, 16'h12FE);
        // Fast source selected, but idle freeze holds the count
        @(posedge mclk) timebase_select <= 3'h4;
        repeat (10) @(posedge mclk);
        #1 chk(count_value, 16'h12FE);
        chk(16'(count_advance), 16'h0000);
        rd(LR, 8'hFE);
        @(posedge mclk) cpu_idle <= 1'b0;
        repeat (12) @(posedge mclk);
        rd(HR, 8'h12);
        rd(HR, 8'h13);
        // Idle with suspend off keeps counting every cycle
        @(posedge mclk) idle_suspend_control <= 1'b0;
        cpu_idle <= 1'b1;
        repeat (3) @(posedge mclk);
        #1 c1 = count_value;
        repeat (20) @(posedge mclk);
        #1 chk(count_value - c1, 16'h0014);
        chk(16'(count_advance), 16'h0001);
        // Wrap from all ones with the interrupt enable off first
        @(posedge mclk) idle_suspend_control <= 1'b1;
        strobe(HW, 8'hFF);
        strobe(LW, 8'hFF);
        chk(16'(counter_overflow_flag), 16'h0000);
        // Back-to-back low then high read across the wrap; count wraps to 0000 on the edge that takes the high read
        @(posedge mclk) low_byte_rd <= 1'b1;
        @(posedge mclk) low_byte_rd <= 1'b0;
        high_byte_rd <= 1'b1;
        cpu_idle <= 1'b0;
        @(posedge mclk) high_byte_rd <= 1'b0;
        #1 chk(16'(rd_data), 16'h00FF);
        chk(count_value, 16'h0000);
        chk(16'(counter_overflow_flag), 16'h0001);
        repeat (3) @(posedge mclk);
        #1 chk(16'(counter_overflow_flag), 16'h0001);
        chk(16'(irq_request), 16'h0000);
        @(posedge mclk) overflow_irq_enable <= 1'b1;
        #1 chk(16'(irq_request), 16'h0001);
        @(posedge mclk) global_irq_enable <= 1'b0;
        #1 chk(16'(irq_request), 16'h0000);
        @(posedge mclk) global_irq_enable <= 1'b1;
        array_irq_enable <= 1'b0;
        #1 chk(16'(irq_request), 16'h0000);
        @(posedge mclk) array_irq_enable <= 1'b1;
        repeat (30) @(posedge mclk);
        #1 chk(16'(counter_overflow_flag), 16'h0001);
        strobe(FC, 8'h00);
        chk(16'(counter_overflow_flag), 16'h0000);
        chk(16'(irq_request), 16'h0000);
        // Every select code over a 48-cycle window
        foreach (rate[i]) begin
            @(posedge mclk) timebase_select <= i[2:0];
            repeat (16) @(posedge mclk);
            #1 c1 = count_value;
            repeat (48) @(posedge mclk);
            #1 chk(count_value - c1, 16'(rate[i]));
        end
        stop_test();
    end
endmodule
`default_nettype wire
